//--- src/rdd_pkg.sv
// shared constants and types of the relay driver serial frame decoder
package rdd_pkg;

  // frame geometry
  localparam int FRAME_W = 16; // bits per frame
  localparam int CMD_HI = 15; // command field, top bit
  localparam int CMD_LO = 14; // command field, low bit
  localparam int ADDR_HI = 10; // register pointer, top bit
  localparam int ADDR_LO = 8; // register pointer, low bit
  localparam int DATA_HI = 7; // data byte, top bit
  localparam int DATA_LO = 0; // data byte, low bit
  localparam int BYTE_W = 8; // clocks per accepted group
  localparam int CNT_W = 3; // width of the modulo-eight clock counter

  // register bank shape
  localparam int REG_N = 8; // pointer reaches eight slots
  localparam int REG_W = 8; // one data byte per slot
  localparam int ADDR_W = 3; // pointer width

  // command codes, kept here so they can be changed in one place
  localparam logic [1:0] CMD_DIAG = 2'h0; // shift out diagnosis only
  localparam logic [1:0] CMD_READ = 2'h1; // answer in the next frame
  localparam logic [1:0] CMD_RESET = 2'h2; // restore all defaults
  localparam logic [1:0] CMD_WRITE = 2'h3; // store data byte

  // slot 6 is the read-only output state, slot 0 is unmapped
  localparam logic [2:0] ADDR_STATUS = 3'h6;
  localparam logic [7:0] REG_WR_MASK = 8'hBE; // slots 1..5 and 7
  // defaults, slot i in byte i: slot 1 comes up as 08, the rest 00
  localparam logic [63:0] REG_DEFAULTS = 64'h0000_0000_0000_0800;

  // one-hot frame tracker states
  typedef enum logic [1:0] {
    RDD_ST_IDLE = 2'h1, // chip select high, link held cleared
    RDD_ST_FRAME = 2'h2 // chip select low, bits moving
  } rdd_state_t;

endpackage : rdd_pkg

//--- src/rdd_reg_bank.sv
// control register bank with byte write and restore-to-defaults
module rdd_reg_bank #(
  parameter int REG_N = rdd_pkg::REG_N,
  parameter int REG_W = rdd_pkg::REG_W,
  parameter int ADDR_W = rdd_pkg::ADDR_W,
  parameter logic [REG_N*REG_W-1:0] DEFAULTS = rdd_pkg::REG_DEFAULTS,
  parameter logic [REG_N-1:0] WR_MASK = rdd_pkg::REG_WR_MASK
) (
  // clock
  input wire logic clock,
  // restore every slot to its default
  input wire logic clear_all,
  // write request
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [REG_W-1:0] wr_data,
  // every slot, slot i in bits [i*REG_W +: REG_W]
  output logic [REG_N*REG_W-1:0] regs_flat
);

  // the pointer must reach exactly the slots that exist
  if (REG_N != (1 << ADDR_W))
  begin : g_bad_shape
    $error("rdd_reg_bank: REG_N must equal 2**ADDR_W");
  end

  // storage, one byte per slot
  logic [REG_W-1:0] mem [REG_N];

  // decode of the write target, one strobe per slot
  wire [REG_N-1:0] hit = wr_en ? (REG_N'(1) << wr_addr) : '0;

  for (genvar i = 0; i < REG_N; i++)
  begin : g_slot
    // clear beats write: a reset command never mixes with a write
    always_ff @(posedge clock)
    begin
      if (clear_all)
        mem[i] <= DEFAULTS[i*REG_W +: REG_W]; // R1 R5
      else if (hit[i] && WR_MASK[i])
        mem[i] <= wr_data; // R6 R7
    end
    assign regs_flat[i*REG_W +: REG_W] = mem[i];
  end

endmodule : rdd_reg_bank

//--- src/rdd_frame_decoder.sv
// serial frame decoder of an eight-channel relay driver
// Function
// R1 - power-on reset loads every register default
// R2 - control and diagnosis registers reachable over link
// R3 - diagnosis-only command leaves all registers unchanged
// R4 - read answer comes in the following frame
// R5 - reset command restores all register defaults
// R6 - write stores data byte into pointed register
// R7 - three-bit pointer selects register for read/write
// R8 - bits between command and pointer are ignored
// R9 - chip select fall loads diagnosis into shifter
// R10 - chip select rise decodes only multiple-of-eight
// R11 - msb first, fall samples, rise drives, float
// R12 - low byte carries the data byte
module rdd_frame_decoder #(
  parameter int CH_N = 8 // relay channels, two diagnosis bits each
) (
  // system clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // reset pin, active low, asynchronous to clock
  input wire logic rst_pin_n,
  // serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // channel side
  input wire logic [2*CH_N-1:0] diag_in,
  input wire logic [rdd_pkg::REG_W-1:0] status_in,
  output logic diag_clr,
  output logic frame_drop,
  // register contents
  output logic [rdd_pkg::REG_N*rdd_pkg::REG_W-1:0] regs_out
);

  // the diagnosis word must fill one frame exactly
  if (2 * CH_N != rdd_pkg::FRAME_W)
  begin : g_bad_ch
    $error("rdd_frame_decoder: CH_N must fill one frame");
  end

  localparam int FW = rdd_pkg::FRAME_W;
  localparam int RW = rdd_pkg::REG_W;
  localparam int AW = rdd_pkg::ADDR_W;

  // ---------------- system domain: pin synchronisers ----------------

  logic cs_meta; // first stage, read only by cs_sync
  logic cs_sync; // chip select on the system clock
  logic cs_prev; // one cycle older, for edge detection
  logic rst_meta; // first stage of the reset pin
  logic rst_sync_n; // reset pin on the system clock

  // two flops on both pins before anything looks at them
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cs_meta <= 1'h1;
      cs_sync <= 1'h1;
      cs_prev <= 1'h1;
      rst_meta <= 1'h1;
      rst_sync_n <= 1'h1;
    end
    else
    begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      rst_meta <= rst_pin_n;
      rst_sync_n <= rst_meta;
    end
  end

  // the pin reset does the same work as the power-on reset
  wire rst_all = sys_rst | ~rst_sync_n; // R1
  wire cs_fall = cs_prev & ~cs_sync;
  wire cs_rise = ~cs_prev & cs_sync;

  // ---------------- system domain: frame tracker state ----------------

  rdd_pkg::rdd_state_t state; // where the frame stands
  logic link_clr; // holds the link logic cleared between frames
  logic [FW-1:0] tx_word; // word handed to the link at frame start
  logic rd_pending; // a read was taken, answer due next frame
  logic [AW-1:0] rd_addr; // pointer of the pending read

  // ---------------- link domain ----------------

  logic [FW-1:0] shifter; // receive shifter, also the daisy-chain path
  logic [rdd_pkg::CNT_W-1:0] bit_cnt; // falling edges, modulo eight
  logic byte_seen; // at least one full group of eight clocked
  logic started; // first falling edge of the frame passed
  logic so_q; // serial output flop

  // before the first falling edge the shifter is the loaded word;
  // tx_word is stable then: it is set well inside the lead time and
  // not touched again until the frame has ended
  wire [FW-1:0] shift_view = started ? shifter : tx_word; // R9

  // sample on the falling edge, msb first, new bit into the lsb
  always_ff @(negedge sclk or posedge link_clr)
  begin
    if (link_clr)
    begin
      shifter <= '0;
      bit_cnt <= '0;
      byte_seen <= 1'h0;
      started <= 1'h0;
    end
    else
    begin
      shifter <= {shift_view[FW-2:0], si}; // R11
      bit_cnt <= bit_cnt + 1'h1;
      started <= 1'h1;
      if (bit_cnt == rdd_pkg::CNT_W'(rdd_pkg::BYTE_W - 1))
        byte_seen <= 1'h1;
    end
  end

  // drive on the rising edge, so the host samples a settled bit
  always_ff @(posedge sclk or posedge link_clr)
  begin
    if (link_clr)
      so_q <= 1'h0;
    else
      so_q <= shift_view[FW-1]; // R11
  end

  assign so = so_q;

  // ---------------- system domain: frame decode ----------------

  // the link side is quiet once chip select is high (clock low and
  // link_clr still low), so its flops are read as stable words here
  wire count_ok = byte_seen && (bit_cnt == '0); // R10
  wire take = cs_rise && (state == rdd_pkg::RDD_ST_FRAME);
  wire frame_take = take && count_ok; // R10
  wire [1:0] f_cmd = shifter[rdd_pkg::CMD_HI:rdd_pkg::CMD_LO]; // R3
  // bits 13..11 are never looked at
  wire [AW-1:0] f_addr = shifter[rdd_pkg::ADDR_HI:rdd_pkg::ADDR_LO]; // R7 R8
  wire [RW-1:0] f_data = shifter[rdd_pkg::DATA_HI:rdd_pkg::DATA_LO]; // R12

  // command strobes, only for a frame with a good clock count
  wire do_write = frame_take && (f_cmd == rdd_pkg::CMD_WRITE); // R6
  wire do_reset = frame_take && (f_cmd == rdd_pkg::CMD_RESET); // R5
  wire do_read = frame_take && (f_cmd == rdd_pkg::CMD_READ); // R4

  // register bank: power-on, pin reset and reset command all clear
  wire bank_clear = rst_all | do_reset; // R1 R5

  rdd_reg_bank #(
    .REG_N(rdd_pkg::REG_N),
    .REG_W(RW),
    .ADDR_W(AW),
    .DEFAULTS(rdd_pkg::REG_DEFAULTS),
    .WR_MASK(rdd_pkg::REG_WR_MASK)
  ) u_bank (
    .clock(clock),
    .clear_all(bank_clear),
    .wr_en(do_write),
    .wr_addr(f_addr),
    .wr_data(f_data),
    .regs_flat(regs_out)
  );

  // read answer: status slot shows the live output state
  wire [RW-1:0] bank_byte = regs_out[{rd_addr, 3'h0} +: RW]; // R7
  wire [RW-1:0] rd_byte = (rd_addr == rdd_pkg::ADDR_STATUS) ?
    status_in : bank_byte; // R2
  wire [FW-1:0] read_word = {rdd_pkg::CMD_READ, 3'h0, rd_addr, rd_byte};
  // a pending read answers instead of the diagnosis word
  wire [FW-1:0] next_tx = rd_pending ? read_word : diag_in; // R4 R9

  // frame tracker: opens the link at the fall, closes it at the rise
  always_ff @(posedge clock)
  begin
    if (rst_all)
    begin
      state <= rdd_pkg::RDD_ST_IDLE;
      link_clr <= 1'h1;
      so_oe <= 1'h0;
      tx_word <= '0;
    end
    else
    begin
      case (state)
        rdd_pkg::RDD_ST_IDLE:
        begin
          if (cs_fall)
          begin
            tx_word <= next_tx; // R9
            link_clr <= 1'h0;
            so_oe <= 1'h1;
            state <= rdd_pkg::RDD_ST_FRAME;
          end
        end
        rdd_pkg::RDD_ST_FRAME:
        begin
          if (cs_rise)
          begin
            link_clr <= 1'h1;
            so_oe <= 1'h0; // R11
            state <= rdd_pkg::RDD_ST_IDLE;
          end
        end
        default:
        begin
          link_clr <= 1'h1;
          so_oe <= 1'h0;
          state <= rdd_pkg::RDD_ST_IDLE;
        end
      endcase
    end
  end

  // read bookkeeping: the answer is loaded at the next fall, and that
  // next frame may itself carry a new command
  always_ff @(posedge clock)
  begin
    if (rst_all)
    begin
      rd_pending <= 1'h0;
      rd_addr <= '0;
    end
    else if (do_read)
    begin
      rd_pending <= 1'h1; // R4
      rd_addr <= f_addr; // R7
    end
    else if (cs_fall && state == rdd_pkg::RDD_ST_IDLE)
      rd_pending <= 1'h0;
  end

  // one-cycle pulses: flags cleared at every frame end, bad counts
  // reported; a bad count still clears, since the flags were read
  always_ff @(posedge clock)
  begin
    if (rst_all)
    begin
      diag_clr <= 1'h0;
      frame_drop <= 1'h0;
    end
    else
    begin
      diag_clr <= take; // R10
      frame_drop <= take && !count_ok; // R10
    end
  end

  // ---------------- checks ----------------

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_reset_defaults: assert property (
    rst_all |=> regs_out == rdd_pkg::REG_DEFAULTS) // R1
    else $error("registers not at defaults after reset");

  a_cmd_reset: assert property (
    do_reset |=> regs_out == rdd_pkg::REG_DEFAULTS) // R5
    else $error("reset command did not restore defaults");

  a_write_store: assert property (
    do_write && rdd_pkg::REG_WR_MASK[f_addr] && !rst_all
    |=> regs_out[{$past(f_addr), 3'h0} +: RW] == $past(f_data)) // R6
    else $error("write data not stored at pointer");

  a_write_readonly: assert property (
    do_write && !rdd_pkg::REG_WR_MASK[f_addr] && !rst_all
    |=> $stable(regs_out)) // R7
    else $error("write changed a read-only or unmapped slot");

  a_diag_only: assert property (
    frame_take && f_cmd == rdd_pkg::CMD_DIAG && !rst_all
    |=> $stable(regs_out)) // R3
    else $error("diagnosis-only frame changed a register");

  a_bad_count: assert property (
    take && !count_ok && !rst_all
    |=> $stable(regs_out) && frame_drop) // R10
    else $error("frame with bad clock count was decoded");

  a_read_answer: assert property (
    rd_pending && cs_fall && state == rdd_pkg::RDD_ST_IDLE && !rst_all
    |=> tx_word[FW-1:FW-2] == rdd_pkg::CMD_READ
    && tx_word[rdd_pkg::ADDR_HI:rdd_pkg::ADDR_LO] == $past(rd_addr)
    && !rd_pending) // R4
    else $error("read answer not loaded in following frame");

  a_read_defer: assert property (
    do_read && !rst_all |=> rd_pending && !so_oe) // R4
    else $error("read answered inside its own frame");

  a_diag_load: assert property (
    !rd_pending && cs_fall && state == rdd_pkg::RDD_ST_IDLE && !rst_all
    |=> tx_word == $past(diag_in) && so_oe && !link_clr) // R9
    else $error("diagnosis not loaded at chip select fall");

  a_diag_clear: assert property (
    take && !rst_all |=> diag_clr ##1 !diag_clr) // R10
    else $error("diagnosis clear pulse wrong");

  a_float_idle: assert property (
    take && !rst_all |=> (!so_oe && link_clr) [*2]) // R11
    else $error("output still driven after chip select rise");

  c_write: cover property (do_write);
  c_read_pair: cover property (do_read ##[1:1000] (rd_pending && cs_fall));
  c_reset_cmd: cover property (do_reset);
  c_bad_count: cover property (take && !count_ok);

endmodule : rdd_frame_decoder

//--- verif/rdd_host_model.sv
// host side of the serial link: frame master making clock, select and data
module rdd_host_model (
  // link pins toward the device
  output logic sclk,
  output logic cs_n,
  output logic si,
  // answer line as the host sees it
  input wire logic so
);
  timeunit 1ns;
  timeprecision 1ps;

  // link idle: clock low, no frame open
  initial
  begin
    sclk = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
  end

  // one frame of n bits, msb first; last 16 answer bits come back
  task automatic xfer(input int n, input logic [23:0] tx,
                      output logic [15:0] rx);
    rx = 16'h0000;
    #7;
    // select with clock low; lead time covers shifter load
    cs_n = 1'h0;
    #260;
    for (int i = n - 1; i >= 0; i--)
    begin
      si = tx[i];
      #40 sclk = 1'h1;
      #80 sclk = 1'h0;
      // device samples si here; its answer changed at the rise
      rx = {rx[14:0], so};
      #40;
    end
    // lag, then release; the freed data line must not hold its value
    #220 cs_n = 1'h1;
    si = ~si;
    #300;
  endtask : xfer
endmodule : rdd_host_model

//--- verif/relay_driver_spi_frame_decoder_tb_top.sv
// self-checking bench of the relay driver serial frame decoder
module relay_driver_spi_frame_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock, sys_rst, rst_pin_n, so, so_oe, diag_clr, frame_drop;
  logic so_line, junk; // host view of the answer line
  wire sclk, cs_n, si;
  logic [15:0] diag_in, rx;
  logic [7:0] status_in, d;
  logic [23:0] f; // frame under construction
  logic [63:0] regs_out;
  logic [7:0] ex [8]; // expected slot contents
  logic [64:0] q [$]; // expected {frame_drop, regs_out} per frame end
  int fail_count = 0;
  int comparisons = 0;

  rdd_frame_decoder dut (.clock(clock), .sys_rst(sys_rst),
    .rst_pin_n(rst_pin_n), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .diag_in(diag_in), .status_in(status_in),
    .diag_clr(diag_clr), .frame_drop(frame_drop), .regs_out(regs_out));
  rdd_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so_line));

  // floating output: host sees a changing pattern, never a held value
  assign so_line = so_oe ? so : junk;

  // system clock, 20 ns
  initial
  begin
    clock = 1'h0;
    junk = 1'h0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) junk <= ~junk;

  task automatic check(input logic [64:0] got, input logic [64:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [63:0] pk();
    logic [63:0] r;
    for (int i = 0; i < 8; i++)
      r[8*i +: 8] = ex[i];
    return r;
  endfunction : pk

  task automatic defaults();
    for (int i = 0; i < 8; i++)
      ex[i] = rdd_pkg::REG_DEFAULTS[8*i +: 8];
  endtask : defaults

  // note the outcome, then send the frame
  task automatic run(input int n, input logic [23:0] tx, input logic drop);
    q.push_back({drop, pk()});
    host.xfer(n, tx, rx);
  endtask : run

  // frame end: take the oldest note and compare
  always @(negedge clock)
    if (diag_clr === 1'h1)
    begin
      if (q.size() == 0)
        check(65'h0, 65'h1);
      else
        check({frame_drop, regs_out}, q.pop_front());
    end

  task automatic summarize();
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // watchdog: the frames need well under a quarter of this
  initial
  begin
    #1ms;
    fail_count++;
    summarize();
  end

  initial
  begin
    sys_rst = 1'h1;
    rst_pin_n = 1'h1;
    diag_in = 16'h0000;
    status_in = 8'h00;
    void'($urandom(32'hD081));
    repeat (3) @(negedge clock);
    sys_rst = 1'h0;
    defaults();
    repeat (4) @(negedge clock);
    check(65'(regs_out), 65'(pk()));
    // every slot written, ignored bits random; 0 and 6 refuse
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($urandom);
      if (rdd_pkg::REG_WR_MASK[i])
        ex[i] = d;
      f = {8'h00, rdd_pkg::CMD_WRITE, 3'($urandom), 3'(i), d};
      run(16, f, 1'h0);
    end
    // diagnosis only: word loaded at select, registers kept
    @(negedge clock);
    diag_in = 16'($urandom);
    run(16, {8'h00, rdd_pkg::CMD_DIAG, 14'h0000}, 1'h0);
    check(65'(rx), 65'(diag_in));
    // read a control slot and the status slot, answer one frame later
    for (int k = 3; k <= 6; k += 3)
    begin
      @(negedge clock);
      status_in = 8'($urandom);
      diag_in = 16'($urandom);
      f = {8'h00, rdd_pkg::CMD_READ, 3'h0, 3'(k), 8'h00};
      run(16, f, 1'h0);
      check(65'(rx), 65'(diag_in));
      run(16, {8'h00, rdd_pkg::CMD_DIAG, 14'h0000}, 1'h0);
      d = (k == 6) ? status_in : ex[k];
      check(65'(rx), 65'({5'h08, 3'(k), d}));
    end
    // short frame dropped; a 24-bit frame decodes its last 16 bits
    d = 8'($urandom);
    run(12, {16'h0000, d}, 1'h1);
    ex[2] = d;
    run(24, {8'hA5, rdd_pkg::CMD_WRITE, 3'h0, 3'h2, d}, 1'h0);
    check(65'(so_oe), 65'h0);
    // reset command restores every default
    defaults();
    run(16, {8'h00, rdd_pkg::CMD_RESET, 14'h0000}, 1'h0);
    // reset pin after a write
    ex[7] = 8'h5A;
    run(16, {8'h00, rdd_pkg::CMD_WRITE, 6'h07, 8'h5A}, 1'h0);
    @(negedge clock);
    rst_pin_n = 1'h0;
    repeat (4) @(negedge clock);
    rst_pin_n = 1'h1;
    defaults();
    repeat (4) @(negedge clock);
    check(65'(regs_out), 65'(pk()));
    check(65'(q.size()), 65'h0);
    summarize();
  end
endmodule : relay_driver_spi_frame_decoder_tb_top
